/* File: src/cec_pkg.sv */
// Purpose: Shared constants for the comparator event control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Control word is 16 bits; the upper half of the bus reads zero

package cec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int unsigned  CEC_ADDR_W      = 12;
    localparam logic [11:0]  CEC_OFS_CTRL    = 12'h000;
    localparam logic [11:0]  CEC_OFS_STATUS  = 12'h004;
    localparam logic [11:0]  CEC_OFS_IRQ_EN  = 12'h008;
    localparam logic [11:0]  CEC_OFS_IRQ_CLR = 12'h00c;

    ////////////////////////////////////////////////////////////////////////
    // Control word layout
    localparam int unsigned  CEC_CTRL_W      = 16;
    localparam int unsigned  CEC_ON_BIT      = 15;
    localparam int unsigned  CEC_OE_BIT      = 14;
    localparam int unsigned  CEC_INV_BIT     = 13;
    localparam int unsigned  CEC_LP_BIT      = 12;
    localparam int unsigned  CEC_EVT_BIT     = 9;
    localparam int unsigned  CEC_RES_BIT     = 8;
    localparam int unsigned  CEC_EDGE_LO     = 6;
    localparam int unsigned  CEC_REF_BIT     = 4;
    localparam int unsigned  CEC_CH_LO       = 0;
    // Plain storage bits; event flag and result are kept apart
    localparam logic [15:0]  CEC_CTRL_WMASK  = 16'hf0d3;
    localparam logic [15:0]  CEC_CTRL_RESET  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear layout
    localparam int unsigned  CEC_IRQ_W       = 2;
    localparam int unsigned  CEC_IRQ_EVENT   = 0;
    localparam int unsigned  CEC_IRQ_CHANGE  = 1;
    localparam logic [1:0]   CEC_IRQ_RESET   = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Event edge selection codes
    typedef enum logic [1:0]
    {
        CEC_EDGE_OFF  = 2'h0,
        CEC_EDGE_RISE = 2'h1,
        CEC_EDGE_FALL = 2'h2,
        CEC_EDGE_ANY  = 2'h3
    } cec_edge_t;

    // True for any offset that holds a register
    function automatic logic cec_mapped(input logic [11:0] addr);
        cec_mapped = (addr == CEC_OFS_CTRL) || (addr == CEC_OFS_STATUS) ||
                     (addr == CEC_OFS_IRQ_EN) || (addr == CEC_OFS_IRQ_CLR);
    endfunction : cec_mapped

endpackage : cec_pkg

/* File: src/cec_edge_detect.sv */
// Purpose: Polarity and transition detection of the comparator output
// Assumes: rawResult is synchronous to sys_clk
// Notes:   Edges are seen only after two enabled cycles in a row

module cec_edge_detect
    import cec_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  chanOn,
    input  wire logic  invert,
    input  wire logic  rawResult,
    output logic       result,
    output logic       rise,
    output logic       fall
);

    logic  prev;
    logic  valid;
    logic  prevValid;
    logic  next_result;
    logic  next_prev;
    logic  next_valid;
    logic  next_prevValid;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // Disabled channel reads zero and arms nothing
        next_result    = chanOn ? (rawResult ^ invert) : 1'b0;
        next_valid     = chanOn;
        next_prev      = result;
        next_prevValid = valid & chanOn;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            result    <= 1'b0;
            prev      <= 1'b0;
            valid     <= 1'b0;
            prevValid <= 1'b0;
        end
        else
        begin
            result    <= next_result;
            prev      <= next_prev;
            valid     <= next_valid;
            prevValid <= next_prevValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prevents a false edge when the channel is switched on
    assign rise = chanOn & valid & prevValid & result & ~prev;
    assign fall = chanOn & valid & prevValid & ~result & prev;

endmodule : cec_edge_detect

/* File: src/cec_comparator_ctrl.sv */
// Purpose: APB control and event logic for one comparator channel
// Assumes: APB master, zero wait states, front end output synchronous
// Notes:   Event flag blocks triggers until software writes it to zero
//
// Chosen here: register access over APB and the placing of the registers.

////////////////////////////////////////////////////////////////////////////
module cec_comparator_ctrl
    import cec_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [CEC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   rawCompare,
    output logic                        comparatorEnable,
    output logic                        lowPowerMode,
    output logic                        referenceSelect,
    output logic      [1:0]             inputChannelSelect,
    output logic                        compareOutputPin,
    output logic                        compareOutputPinEnableN,
    output logic                        triggerPulse,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [CEC_CTRL_W-1:0]  ctrl;
    logic [CEC_CTRL_W-1:0]  next_ctrl;
    logic                   eventFlag;
    logic                   next_eventFlag;
    logic [CEC_IRQ_W-1:0]   irqStatus;
    logic [CEC_IRQ_W-1:0]   next_irqStatus;
    logic [CEC_IRQ_W-1:0]   irqEnable;
    logic [CEC_IRQ_W-1:0]   next_irqEnable;
    logic [31:0]            next_prdata;
    logic                   next_triggerPulse;
    logic                   next_compareOutputPin;
    logic                   next_compareOutputPinEnableN;
    logic                   next_irq;

    logic                   chanOn;
    logic                   pinEnable;
    logic                   invert;
    cec_edge_t              edgeSel;
    logic                   result;
    logic                   rise;
    logic                   fall;
    logic                   edgeMatch;
    logic                   trigger;
    logic [CEC_CTRL_W-1:0]  ctrlView;

    logic                   setupPhase;
    logic                   wrAccess;
    logic                   wrCtrl;
    logic                   wrIrqEn;
    logic                   wrIrqClr;

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    assign chanOn    = ctrl[CEC_ON_BIT];
    assign pinEnable = ctrl[CEC_OE_BIT];
    assign invert    = ctrl[CEC_INV_BIT];
    assign edgeSel   = cec_edge_t'(ctrl[CEC_EDGE_LO +: 2]);

    // Front end configuration straight from the stored bits
    assign comparatorEnable   = chanOn;
    assign lowPowerMode       = ctrl[CEC_LP_BIT];
    assign referenceSelect    = ctrl[CEC_REF_BIT];
    assign inputChannelSelect = ctrl[CEC_CH_LO +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Polarity and transitions
    cec_edge_detect u_edge
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .chanOn    (chanOn),
        .invert    (invert),
        .rawResult (rawCompare),
        .result    (result),
        .rise      (rise),
        .fall      (fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event selection
    always_comb
    begin
        case (edgeSel)
            CEC_EDGE_ANY:  edgeMatch = rise | fall;
            CEC_EDGE_FALL: edgeMatch = invert ? rise : fall;
            CEC_EDGE_RISE: edgeMatch = invert ? fall : rise;
            CEC_EDGE_OFF:  edgeMatch = 1'b0;
            default:       edgeMatch = 1'b0;
        endcase
    end

    // Flag held high masks every later edge
    assign trigger = chanOn & edgeMatch & ~eventFlag;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pwrite;
    assign wrCtrl     = wrAccess && (paddr == CEC_OFS_CTRL);
    assign wrIrqEn    = wrAccess && (paddr == CEC_OFS_IRQ_EN);
    assign wrIrqClr   = wrAccess && (paddr == CEC_OFS_IRQ_CLR);

    // No wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~cec_mapped(paddr);

    // Read view of the control word
    always_comb
    begin
        ctrlView              = ctrl & CEC_CTRL_WMASK;
        ctrlView[CEC_EVT_BIT] = eventFlag;
        ctrlView[CEC_RES_BIT] = result;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and event flag
    always_comb
    begin
        next_ctrl      = ctrl;
        next_eventFlag = eventFlag;
        if (wrCtrl)
        begin
            // Unimplemented and read-only positions never store
            next_ctrl      = pwdata[CEC_CTRL_W-1:0] & CEC_CTRL_WMASK;
            next_eventFlag = pwdata[CEC_EVT_BIT];
        end
        // Hardware set beats a software clear in the same cycle
        if (trigger)
        begin
            next_eventFlag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl      <= CEC_CTRL_RESET;
            eventFlag <= 1'b0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            eventFlag <= next_eventFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable
    always_comb
    begin
        next_irqEnable = irqEnable;
        if (wrIrqEn)
        begin
            next_irqEnable = pwdata[CEC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irqEnable <= CEC_IRQ_RESET;
        end
        else
        begin
            irqEnable <= next_irqEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, write one to clear
    always_comb
    begin
        next_irqStatus = irqStatus;
        if (wrIrqClr)
        begin
            next_irqStatus = irqStatus & ~pwdata[CEC_IRQ_W-1:0];
        end
        // Set after clear so a same-cycle event survives
        if (trigger)
        begin
            next_irqStatus[CEC_IRQ_EVENT] = 1'b1;
        end
        if (rise | fall)
        begin
            next_irqStatus[CEC_IRQ_CHANGE] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irqStatus <= CEC_IRQ_RESET;
        end
        else
        begin
            irqStatus <= next_irqStatus;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Level interrupt, built from next values to stay aligned with status
    always_comb
    begin
        next_irq = |(next_irqStatus & next_irqEnable);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, latched in the setup phase so it is a flop in access
    always_comb
    begin
        next_prdata = prdata;
        if (setupPhase)
        begin
            case (paddr)
                CEC_OFS_CTRL:   next_prdata = {16'h0000, ctrlView};
                CEC_OFS_STATUS: next_prdata = {30'h00000000, irqStatus};
                CEC_OFS_IRQ_EN: next_prdata = {30'h00000000, irqEnable};
                default:        next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else
        begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs; enable is low while the pin is driven
    always_comb
    begin
        // Pin stays low and undriven unless both bits allow it
        next_compareOutputPinEnableN = ~(chanOn & pinEnable);
        next_compareOutputPin        = chanOn & pinEnable & result;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            compareOutputPinEnableN <= 1'b1;
            compareOutputPin        <= 1'b0;
        end
        else
        begin
            compareOutputPinEnableN <= next_compareOutputPinEnableN;
            compareOutputPin        <= next_compareOutputPin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pulse, one cycle per accepted event
    always_comb
    begin
        next_triggerPulse = trigger;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            triggerPulse <= 1'b0;
        end
        else
        begin
            triggerPulse <= next_triggerPulse;
        end
    end

endmodule : cec_comparator_ctrl

/* File: test/cec_front_model.sv */
// Purpose: Model of the analog comparator front end
// Assumes: Bench sets vinAbove at rising edges
// Notes:   Output is junk while the channel is off
module cec_front_model
(
    input  wire logic sys_clk,
    input  wire logic comparatorEnable,
    input  wire logic vinAbove,
    output logic      rawCompare
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Powered down gives no valid level, so toggle rather than hold the last one
    always @(posedge sys_clk) junk <= ~junk;
    assign rawCompare = comparatorEnable ? vinAbove : junk;
endmodule : cec_front_model

/* File: test/cec_comparator_ctrl_chk.sv */
// Purpose: Port assertions for the comparator control block
// Assumes: One clock, async reset high
// Notes:   Sees top ports only
module cec_comparator_ctrl_chk
    import cec_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        comparatorEnable,
    input wire logic        lowPowerMode,
    input wire logic        referenceSelect,
    input wire logic [1:0]  inputChannelSelect,
    input wire logic        compareOutputPin,
    input wire logic        compareOutputPinEnableN,
    input wire logic        triggerPulse,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic acc;
    assign acc = psel && penable;
    ////////////////////////////////////////////////////////////////////////
    a_ready_access: assert property (acc |-> pready)
        else $error("pready low in access");
    a_err_unmapped: assert property (acc && (paddr[1:0] != 2'h0 || paddr > 12'h00c) |-> pslverr)
        else $error("unmapped access without error");
    a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_ctrl_reserved:
        assert property (acc && !pwrite && paddr == CEC_OFS_CTRL
            |-> {prdata[31:16], prdata[11:10], prdata[5], prdata[3:2]} == 21'h0)
        else $error("reserved control bits not zero");
    a_ctrl_applied:
        assert property (acc && pwrite && paddr == CEC_OFS_CTRL |=> comparatorEnable == $past(pwdata[15])
            && lowPowerMode == $past(pwdata[12]) && referenceSelect == $past(pwdata[4])
            && inputChannelSelect == $past(pwdata[1:0]))
        else $error("control outputs do not follow write");
    a_pin_idle:
        assert property (compareOutputPinEnableN |-> !compareOutputPin)
        else $error("undriven pin not low");
    // Pin enable may lag the on bit by one register stage
    a_pin_needs_on:
        assert property (!compareOutputPinEnableN |-> comparatorEnable || $past(comparatorEnable))
        else $error("pin driven while off");
    a_trig_single:
        assert property (triggerPulse |=> !triggerPulse)
        else $error("trigger longer than one cycle");
    a_trig_needs_on:
        assert property (triggerPulse |-> $past(comparatorEnable))
        else $error("trigger while off");
    c_trigger: cover property (triggerPulse);
    c_irq: cover property ($rose(irq));
    c_error: cover property (acc && pslverr);
    c_pin: cover property (!compareOutputPinEnableN && compareOutputPin);
endmodule : cec_comparator_ctrl_chk

bind cec_comparator_ctrl cec_comparator_ctrl_chk u_chk
(
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparatorEnable(comparatorEnable),
    .lowPowerMode(lowPowerMode), .referenceSelect(referenceSelect), .inputChannelSelect(inputChannelSelect),
    .compareOutputPin(compareOutputPin), .compareOutputPinEnableN(compareOutputPinEnableN),
    .triggerPulse(triggerPulse), .irq(irq)
);

/* File: test/cec_comparator_ctrl_tb.sv */
// Purpose: Self-checking bench for the comparator control block
// Assumes: Front end model drives rawCompare
// Notes:   Edge modes run as a loop over code and polarity
module cec_comparator_ctrl_tb
    import cec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vinAbove = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rawCompare, er, comparatorEnable, lowPowerMode, referenceSelect;
    logic        compareOutputPin, compareOutputPinEnableN, triggerPulse, irq;
    logic [1:0]  inputChannelSelect;
    int          fail_count = 0, compares = 0, n;

    always #12.5 sys_clk = ~sys_clk;

    cec_comparator_ctrl u_dut
    (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rawCompare(rawCompare),
        .comparatorEnable(comparatorEnable), .lowPowerMode(lowPowerMode), .referenceSelect(referenceSelect),
        .inputChannelSelect(inputChannelSelect), .compareOutputPin(compareOutputPin),
        .compareOutputPinEnableN(compareOutputPinEnableN), .triggerPulse(triggerPulse), .irq(irq)
    );
    cec_front_model u_front
    (
        .sys_clk(sys_clk), .comparatorEnable(comparatorEnable), .vinAbove(vinAbove), .rawCompare(rawCompare)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Ends a cycle after release so registered outputs have settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : apb

    task automatic vin(input logic v);
        @(posedge sys_clk);
        vinAbove <= v;
    endtask : vin

    task automatic pulses();
        n = 0;
        repeat (6)
        begin
            @(negedge sys_clk);
            n += (triggerPulse === 1'b1);
        end
    endtask : pulses
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk("reset outputs", {23'h0, inputChannelSelect, comparatorEnable, lowPowerMode, referenceSelect,
            compareOutputPin, compareOutputPinEnableN, triggerPulse, irq}, 32'h4);
        apb(1'b0, CEC_OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b1, CEC_OFS_CTRL, 32'hffff_7dff);
        apb(1'b0, CEC_OFS_CTRL, 32'h0);
        chk("ctrl masked", rd, 32'h0000_70d3);
        chk("front end", {28'h0, lowPowerMode, referenceSelect, inputChannelSelect}, 32'hf);
        chk("off pin", {30'h0, comparatorEnable, compareOutputPinEnableN}, 32'h1);
        apb(1'b1, CEC_OFS_CTRL, 32'h0);
        chk("low power off", {31'h0, lowPowerMode}, 32'h0);
        apb(1'b1, CEC_OFS_STATUS, 32'h3);
        apb(1'b0, CEC_OFS_STATUS, 32'h0);
        chk("status read only", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        $display("test registers done");
    endtask : t_regs

    task automatic t_edges();
        logic [1:0] c;
        logic       v;
        apb(1'b1, CEC_OFS_IRQ_EN, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            c = k[1:0];
            v = k[2];
            apb(1'b1, CEC_OFS_CTRL, 32'h0);
            apb(1'b1, CEC_OFS_CTRL, {16'h0, 2'b11, v, 5'h0, c, 6'h0});
            apb(1'b1, CEC_OFS_IRQ_CLR, 32'h3);
            chk("pin level", {30'h0, compareOutputPinEnableN, compareOutputPin}, {31'h0, v});
            apb(1'b0, CEC_OFS_CTRL, 32'h0);
            chk("result bit", {31'h0, rd[8]}, {31'h0, v});
            vin(1'b1);
            pulses();
            chk("rise pulses", n, {31'h0, c == 2'h1 || c == 2'h3});
            chk("pin after rise", {31'h0, compareOutputPin}, {31'h0, ~v});
            vin(1'b0);
            pulses();
            chk("fall pulses", n, {31'h0, c == 2'h2});
            apb(1'b0, CEC_OFS_CTRL, 32'h0);
            chk("event flag", {31'h0, rd[9]}, {31'h0, c != 2'h0});
            chk("irq", {31'h0, irq}, {31'h0, c != 2'h0});
        end
        $display("test edge modes done");
    endtask : t_edges

    task automatic t_rearm();
        apb(1'b1, CEC_OFS_CTRL, 32'h0);
        apb(1'b1, CEC_OFS_IRQ_EN, 32'h0);
        apb(1'b1, CEC_OFS_IRQ_CLR, 32'h3);
        apb(1'b1, CEC_OFS_CTRL, 32'h0000_c0c0);
        vin(1'b1);
        pulses();
        chk("first event", n, 32'h1);
        chk("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b0, CEC_OFS_STATUS, 32'h0);
        chk("status", rd, 32'h3);
        apb(1'b1, CEC_OFS_IRQ_EN, 32'h1);
        chk("irq enabled", {31'h0, irq}, 32'h1);
        apb(1'b1, CEC_OFS_IRQ_CLR, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, CEC_OFS_CTRL, 32'h0000_c0c0);
        vin(1'b0);
        pulses();
        chk("rearmed", n, 32'h1);
        apb(1'b1, CEC_OFS_CTRL, 32'h0000_8000);
        chk("internal only", {30'h0, compareOutputPinEnableN, compareOutputPin}, 32'h2);
        apb(1'b1, CEC_OFS_CTRL, 32'h0000_40c0);
        vin(1'b1);
        pulses();
        chk("off no event", n, 32'h0);
        apb(1'b0, CEC_OFS_CTRL, 32'h0);
        chk("off result", {30'h0, rd[8], compareOutputPinEnableN}, 32'h1);
        $display("test rearm done");
    endtask : t_rearm

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_edges();
        t_rearm();
        wrap_up();
    end

    initial
    begin
        #(25 * 4000);
        fail_count++;
        wrap_up();
    end
endmodule : cec_comparator_ctrl_tb
